// ===== mbd_defines.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the mic bias current detect block.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef MBD_DEFINES_SVH
`define MBD_DEFINES_SVH
`define MBD_ADDR_W 8
`define MBD_DATA_W 16
`define MBD_OFS_CTRL0 8'h06
`define MBD_OFS_HOST 8'h40
`define MBD_OFS_EVENT 8'h41
`define MBD_OFS_STATE 8'h42
`define MBD_BIAS_EN_BIT 0
`define MBD_DET_EN_BIT 1
`define MBD_HOOK_THR_LO 2
`define MBD_HOOK_THR_HI 3
`define MBD_INS_THR_LO 4
`define MBD_INS_THR_HI 6
`define MBD_INS_POL_BIT 0
`define MBD_HOOK_POL_BIT 1
`define MBD_CLK_GATE_BIT 2
`define MBD_SERVO_LO 4
`define MBD_SERVO_HI 7
`define MBD_CTRL0_RST 16'h0000
`define MBD_HOST_RST 16'h0000
`define MBD_CTRL0_WMASK 16'h007f
`define MBD_HOST_WMASK 16'h00f7
`define MBD_HOOK_CONSEC 4'd10
`define MBD_MEAS_PERIOD_NS 1000
`define MBD_CLK_PERIOD_NS 10
`define MBD_MEAS_CYCLES (`MBD_MEAS_PERIOD_NS / `MBD_CLK_PERIOD_NS)
`endif

// ===== mbd_detect.sv
/*
 * mic bias current detect: register slave, comparator synchronisers,
 * hysteresis state, hook filter, polarity-selected sticky event flags.
 * assumes comparators outside, with separate rise/fall trip points,
 * and a host on a plain strobe port with read data one cycle later.
 */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "mbd_defines.svh"
module mbd_detect
	import mbd_pkg::*;
#(
	parameter int MEAS_CYCLES = `MBD_MEAS_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [`MBD_ADDR_W-1:0] addr,
	input wire logic [`MBD_DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [`MBD_DATA_W-1:0] rdata,
	input wire mbd_cmp_s cmp_in,
	input wire logic [1:0] event_clear,
	output mbd_evt_s event_flags,
	output logic [2:0] insertion_current_threshold,
	output logic [1:0] hook_current_threshold,
	output logic bias_output_enable,
	output logic gpio_ins_status,
	output logic gpio_hook_status
);
	// register bus state
	logic [`MBD_DATA_W-1:0] ctrl0_ff;
	logic [`MBD_DATA_W-1:0] host_ff;
	logic [`MBD_DATA_W-1:0] rdata_ff;
	logic [`MBD_DATA_W-1:0] nxt_rdata;
	logic ctrl0_wr;
	logic host_wr;

	// comparator synchronisers; only the second stage is read
	mbd_cmp_s sync1_ff;
	mbd_cmp_s sync2_ff;

	// detection state and the measurement strobe divider
	logic ins_state_ff;
	logic hook_raw_ff;
	logic hook_state_ff;
	logic [3:0] hook_cnt_ff;
	logic [$clog2(MEAS_CYCLES+1)-1:0] meas_cnt_ff;
	logic meas_tick;

	// registered outputs; every top output but rdata comes from one of these
	mbd_evt_s flags_ff;
	logic [2:0] ins_thr_ff;
	logic [1:0] hook_thr_ff;
	logic bias_en_ff;
	logic gpio_ins_ff;
	logic gpio_hook_ff;

	// previous filtered states for edge detection
	logic ins_prev_ff;
	logic hook_prev_ff;

	// qualifiers and one-cycle event strobes
	logic det_en;
	logic clk_ok;
	logic run;
	logic ins_set;
	logic ins_clr;
	logic hook_press;
	logic hook_release;
	logic set_ins_flag;
	logic set_hook_flag;

	// write decodes; a write to any other offset is dropped
	assign ctrl0_wr = wr_stb && (addr == `MBD_OFS_CTRL0);
	assign host_wr = wr_stb && (addr == `MBD_OFS_HOST);

	// control register; upper bits of ctrl0 are reserved and read zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl0_ff <= `MBD_CTRL0_RST;
		end else if (ctrl0_wr) begin
			ctrl0_ff <= wdata & `MBD_CTRL0_WMASK;
		end
	end

	// host clocking and polarity controls; bit 3 is reserved
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			host_ff <= `MBD_HOST_RST;
		end else if (host_wr) begin
			host_ff <= wdata & `MBD_HOST_WMASK;
		end
	end

	assign det_en = ctrl0_ff[`MBD_DET_EN_BIT];
	// filtering runs only when the host keeps clock, gate and a servo up
	assign clk_ok = host_ff[`MBD_CLK_GATE_BIT] &&
		(|host_ff[`MBD_SERVO_HI:`MBD_SERVO_LO]);
	assign run = det_en && clk_ok;

	// read mux; unmapped addresses answer zero
	always_comb begin
		nxt_rdata = 16'h0000;
		case (addr)
			`MBD_OFS_CTRL0: nxt_rdata = ctrl0_ff;
			`MBD_OFS_HOST: nxt_rdata = host_ff;
			`MBD_OFS_EVENT: nxt_rdata = {14'h0000, flags_ff.hook, flags_ff.ins};
			`MBD_OFS_STATE: nxt_rdata = {13'h0000, hook_raw_ff, hook_state_ff,
				ins_state_ff};
			default: nxt_rdata = 16'h0000;
		endcase
	end

	// read data stands one cycle only and is zero otherwise, so the
	// return path can be or-ed with other slaves without a select
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_ff <= 16'h0000;
		end else if (rd_stb) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	// comparators are asynchronous to mclk
	// the first stage may go metastable, so nothing but sync2 reads it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= cmp_in;
			sync2_ff <= sync1_ff;
		end
	end

	// insertion state moves on rise trip, clears on the lower trip or when det_en drops;
	// the state is frozen while unclocked, so a change is seen on return
	assign ins_set = sync2_ff.ins_rise;
	assign ins_clr = !sync2_ff.ins_fall;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ins_state_ff <= 1'b0;
		end else if (!det_en) begin
			ins_state_ff <= 1'b0;
		end else if (run) begin
			if (!ins_state_ff && ins_set) begin
				ins_state_ff <= 1'b1;
			end else if (ins_state_ff && ins_clr) begin
				ins_state_ff <= 1'b0;
			end
		end
	end

	// measurement strobe divider
	// held at zero while not running, so a restart waits a full period
	assign meas_tick = run && (meas_cnt_ff == MEAS_CYCLES - 1);
	always_ff @(posedge mclk) begin
		if (!rst_n || !run || meas_tick) begin
			meas_cnt_ff <= '0;
		end else begin
			meas_cnt_ff <= meas_cnt_ff + 1'b1;
		end
	end

	// per-measurement hook comparator with hysteresis
	always_ff @(posedge mclk) begin
		if (!rst_n || !det_en) begin
			hook_raw_ff <= 1'b0;
		end else if (meas_tick) begin
			if (hook_raw_ff) begin
				hook_raw_ff <= sync2_ff.hook_fall;
			end else begin
				hook_raw_ff <= sync2_ff.hook_rise;
			end
		end
	end

	// filtered hook state changes after ten agreeing measurements; the
	// count restarts whenever a sample disagrees, trading speed for noise
	always_ff @(posedge mclk) begin
		if (!rst_n || !det_en) begin
			hook_cnt_ff <= 4'h0;
			hook_state_ff <= 1'b0;
		end else if (meas_tick) begin
			if (hook_raw_ff == hook_state_ff) begin
				hook_cnt_ff <= 4'h0;
			end else if (hook_cnt_ff == `MBD_HOOK_CONSEC - 4'd1) begin
				hook_cnt_ff <= 4'h0;
				hook_state_ff <= hook_raw_ff;
			end else begin
				hook_cnt_ff <= hook_cnt_ff + 4'd1;
			end
		end
	end

	// insertion edge detector; its reset value equals the state's reset
	// value, so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ins_prev_ff <= 1'b0;
		end else begin
			ins_prev_ff <= ins_state_ff;
		end
	end

	// hook edge detector on the filtered state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hook_prev_ff <= 1'b0;
		end else begin
			hook_prev_ff <= hook_state_ff;
		end
	end

	// polarity is read live; a change while a state is steady makes no
	// event, so the host must wait out contact bounce before changing it
	assign hook_press = hook_state_ff && !hook_prev_ff;
	assign hook_release = !hook_state_ff && hook_prev_ff;
	assign set_ins_flag = det_en && (host_ff[`MBD_INS_POL_BIT] ?
		(!ins_state_ff && ins_prev_ff) :
		(ins_state_ff && !ins_prev_ff));
	assign set_hook_flag = det_en && (host_ff[`MBD_HOOK_POL_BIT] ?
		hook_release :
		hook_press);

	// sticky flags; a new event in the clearing cycle wins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flags_ff <= '0;
		end else begin
			flags_ff.ins <= set_ins_flag ||
				(flags_ff.ins && !event_clear[0]);
			flags_ff.hook <= set_hook_flag ||
				(flags_ff.hook && !event_clear[1]);
		end
	end

	// insertion threshold copy toward the analogue side; the extra
	// stage costs a cycle but keeps the pins straight off a flop
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ins_thr_ff <= 3'h0;
		end else begin
			ins_thr_ff <= ctrl0_ff[`MBD_INS_THR_HI:`MBD_INS_THR_LO];
		end
	end

	// hook threshold copy toward the analogue side
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hook_thr_ff <= 2'h0;
		end else begin
			hook_thr_ff <= ctrl0_ff[`MBD_HOOK_THR_HI:`MBD_HOOK_THR_LO];
		end
	end

	// bias output enable copy
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bias_en_ff <= 1'b0;
		end else begin
			bias_en_ff <= ctrl0_ff[`MBD_BIAS_EN_BIT];
		end
	end

	// gpio levels come from the same filtered states, no fast bypass;
	// they may still bounce, so the host debounces them
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gpio_ins_ff <= 1'b0;
		end else begin
			gpio_ins_ff <= ins_state_ff;
		end
	end

	// hook level, one cycle behind the filtered state like the flag
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gpio_hook_ff <= 1'b0;
		end else begin
			gpio_hook_ff <= hook_state_ff;
		end
	end

	assign rdata = rdata_ff;
	assign event_flags = flags_ff;
	assign insertion_current_threshold = ins_thr_ff;
	assign hook_current_threshold = hook_thr_ff;
	assign bias_output_enable = bias_en_ff;
	assign gpio_ins_status = gpio_ins_ff;
	assign gpio_hook_status = gpio_hook_ff;
endmodule // mbd_detect

// ===== mbd_detect_assertions.sv
/* port assertions for mbd_detect.
   assumes one mclk domain and the bind below. */
`timescale 1ns/1ns
module mbd_detect_chk
	import mbd_pkg::*;
#(parameter int MEAS_CYCLES = 100)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [15:0] rdata,
	input wire mbd_cmp_s cmp_in,
	input wire logic [1:0] event_clear,
	input wire mbd_evt_s event_flags,
	input wire logic [2:0] insertion_current_threshold,
	input wire logic [1:0] hook_current_threshold,
	input wire logic bias_output_enable,
	input wire logic gpio_ins_status,
	input wire logic gpio_hook_status
);
	logic [15:0] run_ff;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// press trip age, saturating so a long hold never wraps
	always_ff @(posedge mclk) begin
		if (!cmp_in.hook_rise) begin
			run_ff <= 16'h0000;
		end else if (run_ff != 16'hffff) begin
			run_ff <= run_ff + 16'h0001;
		end
	end
	a_ctrl_copy: assert property (wr_stb && addr == 8'h06 |->
		##2 {insertion_current_threshold, hook_current_threshold,
		bias_output_enable} == {$past(wdata[6:2], 2), $past(wdata[0], 2)})
		else $error("ctrl copy");
	a_read_flags: assert property (rd_stb && addr == 8'h41 |=>
		rdata == {14'h0, $past(event_flags.hook), $past(event_flags.ins)})
		else $error("flag read");
	a_ins_sticky: assert property (event_flags.ins && !event_clear[0]
		|=> event_flags.ins) else $error("ins flag lost");
	a_hook_sticky: assert property (event_flags.hook
		&& !event_clear[1] |=> event_flags.hook) else $error("hook flag lost");
	a_ins_cause: assert property ($rose(event_flags.ins)
		|-> $changed(gpio_ins_status)) else $error("ins flag cause");
	a_hook_cause: assert property ($rose(event_flags.hook)
		|-> $changed(gpio_hook_status)) else $error("hook flag cause");
	a_ins_delay: assert property ($rose(gpio_ins_status)
		|-> $past(cmp_in.ins_rise, 4)) else $error("ins too early");
	a_hook_filter: assert property ($rose(gpio_hook_status)
		|-> run_ff >= 9 * MEAS_CYCLES + 2) else $error("hook too early");
endmodule // mbd_detect_chk

bind mbd_detect mbd_detect_chk #(.MEAS_CYCLES(MEAS_CYCLES)) u_chk (.*);

// ===== mbd_mic_model.sv
/* accessory model: bias current level to comparator trips.
   assumes level 0 below both trips, 1 between, 2 above. */
`timescale 1ns/1ns
module mbd_mic_model
	import mbd_pkg::*;
(
	input wire logic [1:0] ins_lvl,
	input wire logic [1:0] hook_lvl,
	output mbd_cmp_s cmp
);
	// rise trip sits above fall trip, so level 1 is the dead band
	assign cmp = {ins_lvl[1], |ins_lvl, hook_lvl[1], |hook_lvl};
endmodule // mbd_mic_model

// ===== mbd_pkg.sv
/*
 * types shared by the mic bias current detect block.
 * assumes mbd_defines.svh is on the include path.
 */
package mbd_pkg;
`include "mbd_defines.svh"
	// analogue comparator outputs, raw and unsynchronised
	typedef struct packed {
		logic ins_rise;
		logic ins_fall;
		logic hook_rise;
		logic hook_fall;
	} mbd_cmp_s;
	// latched event flags
	typedef struct packed {
		logic ins;
		logic hook;
	} mbd_evt_s;
endpackage

// ===== testbench.sv
/* self-checking bench for mbd_detect with an accessory model.
   assumes the bound checker and a 100 MHz mclk. */
`timescale 1ns/1ns
module testbench
	import mbd_pkg::*;
;
	localparam int MC = 4;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [1:0] ins_lvl = 2'h0;
	logic [1:0] hook_lvl = 2'h0;
	logic [1:0] event_clear = 2'h0;
	logic [15:0] rdata;
	logic [2:0] ins_thr;
	logic [1:0] hook_thr;
	logic bias_en, g_ins, g_hook;
	mbd_cmp_s cmp;
	mbd_evt_s flags;
	wire logic [15:0] st = {12'h000, flags, g_ins, g_hook};
	int n_mismatch = 0;
	int compares = 0;
	int i;
	// control word beside {ins thr, hook thr, bias enable}
	logic [21:0] rows [4] = '{{16'h0071, 6'h39}, {16'hff8c, 6'h06},
		{16'h0045, 6'h23}, {16'h0038, 6'h1c}};
	mbd_mic_model u_mic (.ins_lvl(ins_lvl), .hook_lvl(hook_lvl), .cmp(cmp));
	mbd_detect #(.MEAS_CYCLES(MC)) u_dut (.mclk(mclk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .cmp_in(cmp), .event_clear(event_clear),
		.event_flags(flags), .insertion_current_threshold(ins_thr),
		.hook_current_threshold(hook_thr), .bias_output_enable(bias_en),
		.gpio_ins_status(g_ins), .gpio_hook_status(g_hook));
	// 100 MHz
	always #5 mclk = ~mclk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// waits end 1 ns past an edge, so outputs are settled
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		{addr, wdata, wr_stb} <= {a, d, 1'b1};
		@(posedge mclk);
		wr_stb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		{addr, rd_stb} <= {a, 1'b1};
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic clr(input logic [1:0] c);
		@(posedge mclk) event_clear <= c;
		@(posedge mclk) event_clear <= 2'h0;
		#1;
	endtask
	task automatic wrap_up();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// the run takes about 400 cycles; a hang past 1000 ends it as a failure
	initial begin
		#10000;
		n_mismatch++;
		wrap_up();
	end
	// reset, control table, then detection cases
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h06, 16'h0000);
		chk({6'h0, ins_thr, hook_thr, bias_en, st[3:0]}, 16'h0);
		for (i = 0; i < 4; i++) begin
			wr(8'h06, rows[i][21:6]);
			// the field copies reach the pins one edge after ctrl0
			tick(1);
			chk({ins_thr, hook_thr, bias_en}, rows[i][5:0]);
			rd(8'h06, rows[i][21:6] & 16'h007f);
		end
		wr(8'h20, 16'hffff);
		rd(8'h20, 16'h0000);
		wr(8'h40, 16'h0014);
		@(posedge mclk) {ins_lvl, hook_lvl} <= 4'ha;
		tick(15 * MC);
		chk(st, 16'h0000);
		@(posedge mclk) hook_lvl <= 2'h0;
		wr(8'h40, 16'h0000);
		wr(8'h06, 16'h0002);
		tick(30);
		chk(st, 16'h0000);
		wr(8'h40, 16'h0014);
		tick(30);
		chk(st, 16'h000a);
		clr(2'h1);
		@(posedge mclk) ins_lvl <= 2'h1;
		tick(20);
		chk(st, 16'h0002);
		@(posedge mclk) ins_lvl <= 2'h0;
		tick(8);
		chk(st, 16'h0000);
		wr(8'h40, 16'h0015);
		@(posedge mclk) ins_lvl <= 2'h2;
		tick(8);
		chk(st, 16'h0002);
		@(posedge mclk) ins_lvl <= 2'h0;
		tick(8);
		chk(st, 16'h0008);
		clr(2'h1);
		// a short press then a gap: the count must start over
		@(posedge mclk) hook_lvl <= 2'h2;
		tick(5 * MC);
		@(posedge mclk) hook_lvl <= 2'h0;
		tick(3 * MC);
		@(posedge mclk) hook_lvl <= 2'h2;
		for (i = 0; i < 15 * MC && g_hook !== 1'b1; i++) tick(1);
		chk({15'h0, i >= 9 * MC && i < 12 * MC}, 16'h0001);
		chk(st, 16'h0005);
		// host-side debounce: the level must hold before it is believed
		tick(2);
		chk({15'h0, g_hook}, 16'h0001);
		clr(2'h2);
		wr(8'h40, 16'h0016);
		@(posedge mclk) hook_lvl <= 2'h0;
		tick(14 * MC);
		chk(st, 16'h0004);
		rd(8'h41, 16'h0002);
		// mid-run reset: fields, flags and gpio levels all return to zero
		wr(8'h06, 16'h007f);
		tick(1);
		chk({10'h0, ins_thr, hook_thr, bias_en}, 16'h003f);
		@(posedge mclk) rst_n <= 1'b0;
		tick(2);
		chk({6'h0, ins_thr, hook_thr, bias_en, st[3:0]}, 16'h0);
		@(posedge mclk) rst_n <= 1'b1;
		rd(8'h40, 16'h0000);
		rd(8'h06, 16'h0000);
		wrap_up();
	end
endmodule // testbench
